// >>> sct_pkg.sv
// Constants and types shared by the SPI clock/timing block, its checker and its bench.
// Assumes one system clock; no other package is needed.
package sct_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] SCT_DIV_ADDR = 8'ha2;
  localparam logic [7:0] SCT_DIV_RESET = 8'h00;

  // ==========================================================================
  // Word and mode encodings
  localparam int SCT_WORD_BITS = 8;
  localparam logic [3:0] SCT_LAST_HALF = 4'hf;
  localparam logic [1:0] SCT_SEL_THREE_WIRE = 2'b00;
  localparam logic [1:0] SCT_SEL_FOUR_WIRE_SLAVE = 2'b01;

  // ==========================================================================
  // Timing, in core clock periods (8 ns at 125 MHz)
  localparam int SCT_CLK_PERIOD_PS = 8000;
  localparam int SCT_SEZ_MAX_CYCLES = 4;
  localparam int SCT_SDZ_MAX_CYCLES = 4;
  localparam int SCT_SOH_MAX_CYCLES = 4;
  localparam int SCT_SLH_MIN_CYCLES = 6;
  localparam int SCT_SLH_MAX_CYCLES = 8;
  // Edge detect plus load register add two cycles on top of the wait count
  localparam logic [3:0] SCT_SLH_WAIT =
    4'((SCT_SLH_MIN_CYCLES + SCT_SLH_MAX_CYCLES) / 2 - 2);

  typedef enum logic [2:0]
  {
    SCT_IDLE = 3'b001,
    SCT_SHIFT = 3'b010,
    SCT_GAP = 3'b100
  } sct_state_type;

endpackage

// >>> sct_buf_if.sv
// Valid/ready carrier between the transfer engine and its word buffer.
// Assumes both ends share one clock.
`timescale 1ns/1ps

interface sct_buf_if #(parameter int WIDTH = 8);
  logic in_valid;
  logic in_ready;
  logic [WIDTH-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [WIDTH-1:0] out_data;

  modport buf_side (input in_valid, input in_data, input out_ready,
                    output in_ready, output out_valid, output out_data);
  modport user_side (output in_valid, output in_data, output out_ready,
                     input in_ready, input out_valid, input out_data);
endinterface // sct_buf_if

// >>> sct_buf.sv
// Small FIFO holding transmit words ahead of the shifter.
// Assumes a synchronous active-high reset and a clock enable that freezes it.
`timescale 1ns/1ps

module sct_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Buffer ports
  sct_buf_if.buf_side bif
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic room_reg;
  logic empty_reg;
  logic push;
  logic pop;

  assign push = bif.in_valid & room_reg;
  assign pop = bif.out_ready & ~empty_reg;
  assign bif.in_ready = room_reg;
  assign bif.out_valid = ~empty_reg;
  assign bif.out_data = mem[rd_ptr_reg];

  always_comb
  begin
    count_next = count_reg;
    if (push & ~pop)
      count_next = count_reg + 1'b1;
    else if (pop & ~push)
      count_next = count_reg - 1'b1;
  end

  // ==========================================================================
  // Storage and pointers
  always_ff @(posedge clock)
  begin
    if (clk_en & push)
      mem[wr_ptr_reg] <= bif.in_data;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      // No room is offered while reset is held
      room_reg <= 1'b0;
      empty_reg <= 1'b1;
    end
    else if (clk_en)
    begin
      if (push)
        wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1;
      count_reg <= count_next;
      // Flags registered so the ready seen outside is a flop
      room_reg <= (count_next != FULL_COUNT);
      empty_reg <= (count_next == '0);
    end
  end
endmodule // sct_buf

// >>> sct_spi_timing.sv
// SPI serial clock generator and byte engine for master and slave roles.
// Assumes all pins are synchronous to clock and the pad logic resolves enables.
// Notes on behaviour
// - Master serial clock period is two times (divider plus one) core clocks.
// - Divider is used only in master role; slave follows external clock.
// - Clock polarity select one inverts idle and active clock levels.
// - Slave drives MISO within four core clocks after select falls.
// - Slave releases MISO within four core clocks after select rises.
// - Slave updates MISO within four core clocks of each shift edge.
// - Slave phase one changes MISO six to eight clocks after last edge.
// - Select mode 00 is three-wire, 01 four-wire slave with select input.
`timescale 1ns/1ps

module sct_spi_timing
  import sct_pkg::*;
#(
  parameter int BUF_DEPTH = 2
) (
  // Clock, reset, enable
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Special function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Configuration
  input wire logic spi_enable,
  input wire logic master_select,
  input wire logic clock_polarity_select,
  input wire logic clock_phase_select,
  input wire logic [1:0] select_mode_bits,
  // Transmit words in
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  // Received words out
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic xfer_busy,
  // Serial pins
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic slave_select_n
);
  import sct_pkg::*;

  sct_buf_if #(.WIDTH(SCT_WORD_BITS)) bif ();

  sct_buf #(.WIDTH(SCT_WORD_BITS), .DEPTH(BUF_DEPTH)) u_buf (
    .clock(clock),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .bif(bif.buf_side)
  );

  sct_state_type state_reg;
  logic [7:0] div_reg;
  logic [7:0] div_cnt_reg;
  logic [3:0] half_cnt_reg;
  logic [3:0] gap_cnt_reg;
  logic [7:0] shift_reg;
  logic samp_reg;
  logic data_out_reg;
  logic sck_out_reg;
  logic sck_prev_reg;
  logic sel_prev_reg;
  logic slave_sel;
  logic master_on;
  logic div_tick;
  logic edge_now;
  logic sample_edge;
  logic shift_edge;
  logic last_edge;
  logic in_bit;
  logic load_word;
  logic [7:0] load_data;

  assign bif.in_valid = tx_valid;
  assign bif.in_data = tx_data;
  assign tx_ready = bif.in_ready;
  assign sck_out = sck_out_reg;
  assign mosi_out = data_out_reg;
  assign miso_out = data_out_reg;

  // ==========================================================================
  // Role and edge decode
  assign master_on = spi_enable & master_select;
  // Three-wire slave is always selected while enabled
  assign slave_sel = spi_enable & ~master_select &
    ((select_mode_bits == SCT_SEL_THREE_WIRE) | ~slave_select_n);
  assign div_tick = master_on & (state_reg == SCT_SHIFT) & (div_cnt_reg == div_reg);
  // Slave edges rely on the peer honouring long clock phases
  assign edge_now = master_on ? div_tick :
    (slave_sel & (state_reg == SCT_SHIFT) & (sck_in != sck_prev_reg));
  // Even half periods end in a leading edge; phase one swaps sample and shift
  assign sample_edge = edge_now & (~half_cnt_reg[0] ^ clock_phase_select);
  assign shift_edge = edge_now & ~(~half_cnt_reg[0] ^ clock_phase_select);
  assign last_edge = edge_now & (half_cnt_reg == SCT_LAST_HALF);
  assign in_bit = master_on ? miso_in : mosi_in;
  assign load_data = bif.out_valid ? bif.out_data : 8'h00;

  always_comb
  begin
    load_word = 1'b0;
    unique case (state_reg)
      SCT_IDLE:
        load_word = (master_on & bif.out_valid) | (slave_sel & ~sel_prev_reg);
      SCT_SHIFT:
        load_word = slave_sel & last_edge & ~clock_phase_select;
      SCT_GAP:
        load_word = slave_sel & (gap_cnt_reg == SCT_SLH_WAIT);
    endcase
  end
  // Slave with an empty buffer sends zeros rather than stalling the peer
  assign bif.out_ready = load_word & clk_en;

  // ==========================================================================
  // Divider register
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      div_reg <= SCT_DIV_RESET;
      sfr_rdata <= 8'h00;
    end
    else if (clk_en)
    begin
      if (sfr_wr & (sfr_addr == SCT_DIV_ADDR))
        div_reg <= sfr_wdata;
      sfr_rdata <= (sfr_addr == SCT_DIV_ADDR) ? div_reg : 8'h00;
    end
  end

  // ==========================================================================
  // Serial clock generation
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      div_cnt_reg <= 8'h00;
      sck_out_reg <= 1'b0;
      sck_oe <= 1'b0;
      mosi_oe <= 1'b0;
      miso_oe <= 1'b0;
    end
    else if (clk_en)
    begin
      // Counter only runs in master role, so a slave ignores the divider
      if (~master_on | (state_reg != SCT_SHIFT) | div_tick)
        div_cnt_reg <= 8'h00;
      else
        div_cnt_reg <= div_cnt_reg + 8'h01;
      if (~master_on | (state_reg != SCT_SHIFT))
        sck_out_reg <= clock_polarity_select;
      else if (div_tick)
        sck_out_reg <= ~sck_out_reg;
      sck_oe <= master_on;
      mosi_oe <= master_on;
      miso_oe <= slave_sel;
    end
  end

  // ==========================================================================
  // Input history for edge detection
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      sck_prev_reg <= 1'b0;
      sel_prev_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      sck_prev_reg <= sck_in;
      sel_prev_reg <= slave_sel;
    end
  end

  // ==========================================================================
  // Transfer engine
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      state_reg <= SCT_IDLE;
      half_cnt_reg <= 4'h0;
      gap_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      samp_reg <= 1'b0;
      data_out_reg <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
      xfer_busy <= 1'b0;
    end
    else if (clk_en)
    begin
      rx_valid <= 1'b0;
      xfer_busy <= (state_reg != SCT_IDLE);
      unique case (state_reg)
        SCT_IDLE:
        begin
          if (load_word)
          begin
            shift_reg <= load_data;
            data_out_reg <= load_data[7];
            half_cnt_reg <= 4'h0;
            state_reg <= SCT_SHIFT;
          end
        end
        SCT_SHIFT:
        begin
          if (~master_on & ~slave_sel)
            state_reg <= SCT_IDLE;
          else if (edge_now)
          begin
            half_cnt_reg <= half_cnt_reg + 4'h1;
            if (sample_edge & clock_phase_select)
              shift_reg <= {shift_reg[6:0], in_bit};
            if (sample_edge & ~clock_phase_select)
              samp_reg <= in_bit;
            if (shift_edge & ~clock_phase_select)
            begin
              shift_reg <= {shift_reg[6:0], samp_reg};
              data_out_reg <= shift_reg[6];
            end
            if (shift_edge & clock_phase_select)
              data_out_reg <= shift_reg[7];
            if (last_edge)
            begin
              rx_valid <= 1'b1;
              rx_data <= clock_phase_select ? {shift_reg[6:0], in_bit} :
                {shift_reg[6:0], samp_reg};
              if (master_on)
                state_reg <= SCT_IDLE;
              else if (clock_phase_select)
              begin
                gap_cnt_reg <= 4'h0;
                state_reg <= SCT_GAP;
              end
              else
              begin
                // Back-to-back slave word: next byte ready on the same edge
                shift_reg <= load_data;
                data_out_reg <= load_data[7];
                half_cnt_reg <= 4'h0;
              end
            end
          end
        end
        SCT_GAP:
        begin
          if (~slave_sel)
            state_reg <= SCT_IDLE;
          else if (load_word)
          begin
            // Replace the held last bit now that the peer has had time to take it after the edge
            shift_reg <= load_data;
            data_out_reg <= load_data[7];
            half_cnt_reg <= 4'h0;
            state_reg <= SCT_SHIFT;
          end
          else
            gap_cnt_reg <= gap_cnt_reg + 4'h1;
        end
      endcase
    end
  end
endmodule // sct_spi_timing

// >>> sct_spi_timing_properties.sv
// Checker for serial clock and pin timing of the SPI block.
// Sees the top module's ports only; bound after the module.
`timescale 1ns/1ps
module sct_spi_timing_props
  import sct_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  // Configuration
  input wire logic spi_enable,
  input wire logic master_select,
  input wire logic clock_polarity_select,
  input wire logic clock_phase_select,
  input wire logic [1:0] select_mode_bits,
  // Status and pins
  input wire logic rx_valid,
  input wire logic xfer_busy,
  input wire logic sck_in,
  input wire logic sck_out,
  input wire logic sck_oe,
  input wire logic mosi_oe,
  input wire logic miso_out,
  input wire logic miso_oe,
  input wire logic slave_select_n
);
  // ==========================================================================
  // Shadow state
  logic [7:0] div_m;
  logic [7:0] gap;
  logic [3:0] tog;
  logic [3:0] sc;
  logic sck_q;
  logic sin_q;
  always_ff @(posedge clock)
    if (sys_rst)
      div_m <= SCT_DIV_RESET;
    else if (sfr_wr && sfr_addr == SCT_DIV_ADDR)
      div_m <= sfr_wdata;
  // Gap may start unknown; it is only trusted after a first toggle
  always_ff @(posedge clock)
  begin
    sck_q <= sck_out;
    sin_q <= sck_in;
    gap <= (sck_out != sck_q) ? 8'h00 : gap + 8'h01;
    sc <= (sck_in != sin_q || sys_rst) ? 4'h0 : sc + {3'h0, sc != 4'hf};
  end
  always_ff @(posedge clock)
    tog <= (sys_rst || !sck_oe) ? 4'h0 : tog + {3'h0, sck_out != sck_q};
  // ==========================================================================
  // Properties
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  AST_SCK_HALF: assert property ($changed(sck_out) && sck_oe && tog != 4'h0 |-> gap == div_m)
    else $error("bad half period");
  AST_BYTE_END: assert property (rx_valid && sck_oe |-> tog == 4'hf && sck_out != sck_q)
    else $error("bad byte length");
  AST_IDLE: assert property (sck_oe && !xfer_busy && !$past(xfer_busy)
    |-> sck_out == $past(clock_polarity_select))
    else $error("bad idle level");
  AST_ROLE: assert property (!$past(master_select) |-> !sck_oe && !mosi_oe)
    else $error("slave drives clock");
  AST_MISO_ON: assert property ($fell(slave_select_n) && !master_select && spi_enable
    && select_mode_bits != SCT_SEL_THREE_WIRE |-> ##[0:4] miso_oe)
    else $error("miso late");
  AST_MISO_OFF: assert property ($rose(slave_select_n) && !master_select
    && select_mode_bits != SCT_SEL_THREE_WIRE |-> ##[0:4] !miso_oe)
    else $error("miso not released");
  AST_MISO_STEP: assert property ($changed(miso_out) && miso_oe && $past(miso_oe) && !master_select
    |-> sc <= 4'h3 || (clock_phase_select && sc >= 4'h5 && sc <= 4'h7))
    else $error("miso change off time");
  AST_THREE_WIRE: assert property ((!master_select && spi_enable
    && select_mode_bits == SCT_SEL_THREE_WIRE) [*4] |-> miso_oe)
    else $error("three-wire not driving");
  COV_MASTER: cover property (rx_valid && sck_oe);
  COV_SLAVE: cover property (rx_valid && !master_select);
  COV_SELECT: cover property ($fell(slave_select_n) ##[1:4] miso_oe);
endmodule // sct_spi_timing_props
bind sct_spi_timing sct_spi_timing_props u_props (.*);

// >>> sct_peer.sv
// Behavioural SPI peer: slave when the device leads, master when it follows.
// Assumes the bench wires its pins straight to the device's serial pins.
`timescale 1ns/1ps
module sct_peer
(
  // Clock
  input wire logic clock,
  // Facing a master
  input wire logic m_sck,
  input wire logic m_mosi,
  input wire logic m_oe,
  input wire logic pha,
  input wire logic [7:0] reply,
  output logic miso,
  // Facing a slave
  input wire logic sdo,
  output logic sck = 1'b0,
  output logic mosi = 1'b0,
  output logic ss_n = 1'b1
);
  logic [8:0] sr;
  logic [7:0] cap;
  logic [7:0] gq[$];
  int tog;
  // ==========================================================================
  // Slave side
  assign miso = m_oe ? sr[8] : ~sr[8];
  always @(posedge clock)
    if (!m_oe)
    begin
      tog = 0;
      sr = pha ? {1'b0, reply} : {reply, 1'b0};
    end
  // Output moves on the clock edge itself, so the master gets a full half period
  always @(m_sck)
    if (m_oe)
    begin
      tog = tog + 1;
      if (tog[0] ^ pha)
        cap = {cap[6:0], m_mosi};
      if (tog == 16)
      begin
        gq.push_back(cap);
        tog = 0;
        sr = pha ? {1'b0, reply} : {reply, 1'b0};
      end
      else if (!(tog[0] ^ pha))
        sr = sr << 1;
    end
  // ==========================================================================
  // Master side
  task automatic frame(input logic [7:0] b, input logic p, output logic [7:0] r);
    int i;
    ss_n = 1'b0;
    for (i = 7; i >= 0; i--)
    begin
      if (!p)
        mosi = b[i];
      repeat (6) @(negedge clock);
      if (!p)
        r[i] = sdo;
      sck = 1'b1;
      if (p)
        mosi = b[i];
      repeat (6) @(negedge clock);
      if (p)
        r[i] = sdo;
      sck = 1'b0;
    end
    repeat (p ? 10 : 3) @(negedge clock);
    ss_n = 1'b1;
    mosi = ~mosi;
    repeat (8) @(negedge clock);
  endtask
endmodule // sct_peer

// >>> tb_spi_clock_rate_and_timing.sv
// Self-checking bench for the SPI clock and timing block.
// Inputs change on the falling edge; the peer model sits on the pins.
`timescale 1ns/1ps
module tb_spi_clock_rate_and_timing;
  import sct_pkg::*;
  logic clock = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, sfr_wr = 1'b0, tx_valid = 1'b0;
  logic spi_enable = 1'b0, master_select = 1'b1, clock_polarity_select = 1'b0;
  logic clock_phase_select = 1'b0;
  logic [1:0] select_mode_bits = SCT_SEL_FOUR_WIRE_SLAVE;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, tx_data = 8'h00, r, sfr_rdata, rx_data;
  logic tx_ready, rx_valid, xfer_busy, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  logic sck_in, mosi_in, miso_in, slave_select_n;
  logic [7:0] rxq[$];
  int n_mismatch = 0, check_count = 0;
  sct_spi_timing uut (.*);
  sct_peer peer (.clock(clock), .m_sck(sck_out), .m_mosi(mosi_out), .m_oe(sck_oe),
    .pha(clock_phase_select), .reply(8'h96), .miso(miso_in), .sdo(miso_out),
    .sck(sck_in), .mosi(mosi_in), .ss_n(slave_select_n));
  // ==========================================================================
  // Tasks
  task automatic wrap_up();
    if (n_mismatch == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    check_count++;
    if (a !== e)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, a, e);
    end
  endtask
  task automatic hang();
    n_mismatch++;
    $display("wrong value at %0t: no answer", $time);
    wrap_up();
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clock);
    sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    sfr_addr = a;
    repeat (2) @(negedge clock);
    chk(sfr_rdata, e);
  endtask
  // Leaves tx_valid high; the caller lowers it on a later step
  task automatic push(input logic [7:0] d);
    int i;
    tx_valid = 1'b1;
    tx_data = d;
    for (i = 0; i < 500 && tx_ready !== 1'b1; i++)
      @(negedge clock);
    if (tx_ready !== 1'b1)
      hang();
    @(negedge clock);
  endtask
  task automatic wait_rx(input int n);
    int i;
    for (i = 0; i < 3000 && rxq.size() < n; i++)
      @(negedge clock);
    if (rxq.size() < n)
      hang();
  endtask
  always @(posedge clock)
    if (rx_valid === 1'b1)
      rxq.push_back(rx_data);
  initial
    forever #4 clock = ~clock;
  // ==========================================================================
  // Sequence
  initial
  begin
    repeat (3) @(negedge clock);
    sys_rst = 1'b0;
    repeat (2) @(negedge clock);
    rd(SCT_DIV_ADDR, SCT_DIV_RESET);
    wr(8'h55, 8'h11);
    rd(8'h55, 8'h00);
    wr(SCT_DIV_ADDR, 8'h03);
    rd(SCT_DIV_ADDR, 8'h03);
    push(8'ha5);
    push(8'h3c);
    tx_valid = 1'b0;
    @(negedge clock);
    chk(tx_ready, 8'h00);
    spi_enable = 1'b1;
    push(8'he1);
    tx_valid = 1'b0;
    wait_rx(3);
    chk(rxq[0], 8'h96);
    chk(rxq[1], 8'h96);
    chk(rxq[2], 8'h96);
    chk(peer.gq[0], 8'ha5);
    chk(peer.gq[1], 8'h3c);
    chk(peer.gq[2], 8'he1);
    spi_enable = 1'b0;
    clock_polarity_select = 1'b1;
    clock_phase_select = 1'b1;
    wr(SCT_DIV_ADDR, 8'h00);
    repeat (2) @(negedge clock);
    spi_enable = 1'b1;
    push(8'h81);
    tx_valid = 1'b0;
    wait_rx(4);
    chk(rxq[3], 8'h96);
    chk(peer.gq[3], 8'h81);
    spi_enable = 1'b0;
    master_select = 1'b0;
    clock_polarity_select = 1'b0;
    clock_phase_select = 1'b0;
    repeat (2) @(negedge clock);
    spi_enable = 1'b1;
    push(8'h5a);
    tx_valid = 1'b0;
    peer.frame(8'hc3, 1'b0, r);
    chk(r, 8'h5a);
    wait_rx(5);
    chk(rxq[4], 8'hc3);
    chk(miso_oe, 8'h00);
    clock_phase_select = 1'b1;
    push(8'h24);
    push(8'hc5);
    tx_valid = 1'b0;
    peer.frame(8'h7e, 1'b1, r);
    chk(r, 8'h24);
    wait_rx(6);
    chk(rxq[5], 8'h7e);
    select_mode_bits = SCT_SEL_THREE_WIRE;
    repeat (6) @(negedge clock);
    chk(miso_oe, 8'h01);
    wrap_up();
  end
endmodule // tb_spi_clock_rate_and_timing
